/* timer_counter_pwm_cfg.svh */
`ifndef TIMER_COUNTER_PWM_CFG_SVH
`define TIMER_COUNTER_PWM_CFG_SVH

// ==========================================================
// Counter geometry
`define TC_COUNT_W 16
`define TC_COUNT_MAX 16'hffff
`define TC_PRESC_W 10

// ==========================================================
// Interrupt flag positions
`define TC_FLAG_W 3
`define TC_FLAG_OVF 0
`define TC_FLAG_CMP 1
`define TC_FLAG_CAP 2

// ==========================================================
// Clock source codes
`define TC_SRC_CORE 2'h0
`define TC_SRC_PIN_RISE 2'h1
`define TC_SRC_PIN_FALL 2'h2
`define TC_SRC_STOP 2'h3

// ==========================================================
// Prescaler codes and their divide masks
`define TC_PRE_STOP 3'h0
`define TC_PRE_DIV1 3'h1
`define TC_PRE_DIV8 3'h2
`define TC_PRE_DIV64 3'h3
`define TC_PRE_DIV256 3'h4
`define TC_PRE_DIV1024 3'h5
`define TC_MASK_DIV1 10'h000
`define TC_MASK_DIV8 10'h007
`define TC_MASK_DIV64 10'h03f
`define TC_MASK_DIV256 10'h0ff
`define TC_MASK_DIV1024 10'h3ff

// ==========================================================
// Stand-alone preload values and the reset pin enable (used in both bus and stand-alone mode)
`define TC_SA_MODE 2'h2
`define TC_SA_CLK_SEL 2'h0
`define TC_SA_PRESC 3'h1
`define TC_SA_PERIOD 16'h00ff
`define TC_SA_COMPARE 16'h0080
`define TC_RESET_PIN_ENABLE 1'b1

`endif

/* timer_counter_pwm_pkg.sv */
package timer_counter_pwm_pkg;

    typedef enum logic [1:0] {
        MODE_WATCHDOG,
        MODE_CTC,
        MODE_FAST_PWM,
        MODE_PFC_PWM
    } tc_mode_type;

    typedef struct packed {
        logic clk_meta;
        logic clk_sync;
        logic clk_prev;
        logic rst_meta;
        logic rst_sync;
        logic cap_meta;
        logic cap_sync;
        logic cap_prev;
        logic [9:0] presc;
        logic [15:0] count;
        logic down;
        logic [15:0] period_buf;
        logic [15:0] compare_buf;
        logic wave;
        logic [15:0] capture;
        logic [2:0] flags;
        logic irq;
        logic wake;
    } tc_state_type;

endpackage

/* timer_counter_pwm.sv */
`include "timer_counter_pwm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module timer_counter_pwm
    import timer_counter_pwm_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_bus_mode,
    input wire logic [1:0] i_mode,
    input wire logic [1:0] i_clock_select,
    input wire logic [2:0] i_prescale_select,
    input wire logic [15:0] i_period,
    input wire logic [15:0] i_compare,
    input wire logic i_capture_enable,
    input wire logic [2:0] i_irq_mask,
    input wire logic [2:0] i_irq_clear,
    input wire logic i_watchdog_kick,
    input wire logic i_counter_clock_in,
    input wire logic i_counter_reset_low,
    input wire logic i_capture_trigger_in,
    output logic [15:0] o_count_value,
    output logic [15:0] o_capture_value_reg,
    output logic o_waveform_out,
    output logic o_counter_irq_out,
    output logic o_wake_irq,
    output logic [2:0] o_irq_flags,
    output logic o_count_down
);

    // ==========================================================
    // Prescaler decode
    function automatic logic [9:0] presc_mask(input logic [2:0] sel);
        logic [9:0] m;
        m = `TC_MASK_DIV1;
        unique case (sel)
            `TC_PRE_DIV8: m = `TC_MASK_DIV8;
            `TC_PRE_DIV64: m = `TC_MASK_DIV64;
            `TC_PRE_DIV256: m = `TC_MASK_DIV256;
            `TC_PRE_DIV1024: m = `TC_MASK_DIV1024;
            default: m = `TC_MASK_DIV1;
        endcase
        return m;
    endfunction

    function automatic logic presc_running(input logic [2:0] sel);
        return (sel != `TC_PRE_STOP) && (sel <= `TC_PRE_DIV1024);
    endfunction

    // ==========================================================
    // Edge and mask decode
    function automatic logic rose_edge(input logic cur, input logic last);
        return cur && !last;
    endfunction

    function automatic logic fell_edge(input logic cur, input logic last);
        return !cur && last;
    endfunction

    function automatic logic masked_any(input logic [2:0] bits, input logic [2:0] mask);
        return |(bits & mask);
    endfunction

    // ==========================================================
    // State
    tc_state_type st_ff;
    tc_state_type nxt_st;

    // ==========================================================
    // Effective configuration
    tc_mode_type mode;
    logic [1:0] clk_sel;
    logic [2:0] presc_sel;
    logic [15:0] period_in;
    logic [15:0] compare_in;
    logic pin_reset;
    logic src_tick;
    logic tick;
    logic is_pwm;
    logic [2:0] events;
    logic [2:0] flags_kept;
    logic cap_edge;
    logic cap_allowed;

    always_comb begin
        if (i_bus_mode) begin
            mode = tc_mode_type'(i_mode);
            clk_sel = i_clock_select;
            presc_sel = i_prescale_select;
            period_in = i_period;
            compare_in = i_compare;
        end else begin
            // Stand-alone: values fixed at configuration
            mode = tc_mode_type'(`TC_SA_MODE);
            clk_sel = `TC_SA_CLK_SEL;
            presc_sel = `TC_SA_PRESC;
            period_in = `TC_SA_PERIOD;
            compare_in = `TC_SA_COMPARE;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        events = '0;

        // ==========================================================
        // Pin synchronisers; the first stage is never read, edges compare the second and third stages
        nxt_st.clk_meta = i_counter_clock_in;
        nxt_st.clk_sync = st_ff.clk_meta;
        nxt_st.clk_prev = st_ff.clk_sync;
        nxt_st.rst_meta = i_counter_reset_low;
        nxt_st.rst_sync = st_ff.rst_meta;
        nxt_st.cap_meta = i_capture_trigger_in;
        nxt_st.cap_sync = st_ff.cap_meta;
        nxt_st.cap_prev = st_ff.cap_sync;

        // ==========================================================
        // Reset pin and mode class
        // Sync stages clear to zero, so the pin reset also runs for two cycles after
        // i_reset and loads the period and compare buffers before the first tick
        pin_reset = `TC_RESET_PIN_ENABLE && !st_ff.rst_sync;
        is_pwm = (mode == MODE_FAST_PWM) || (mode == MODE_PFC_PWM);

        // ==========================================================
        // Clock source and prescaler
        unique case (clk_sel)
            `TC_SRC_CORE: src_tick = 1'b1;
            `TC_SRC_PIN_RISE: src_tick = rose_edge(st_ff.clk_sync, st_ff.clk_prev);
            `TC_SRC_PIN_FALL: src_tick = fell_edge(st_ff.clk_sync, st_ff.clk_prev);
            `TC_SRC_STOP: src_tick = 1'b0;
        endcase
        // The prescaler runs free, so the first period after a new division may be short
        tick = 1'b0;
        if (src_tick && presc_running(presc_sel)) begin
            nxt_st.presc = st_ff.presc + 10'h001;
            tick = (st_ff.presc & presc_mask(presc_sel)) == presc_mask(presc_sel);
        end

        // ==========================================================
        // Period and compare buffers
        // Non-PWM modes follow the inputs directly; PWM modes hold buffered copies
        if (!is_pwm) begin
            nxt_st.period_buf = period_in;
            nxt_st.compare_buf = compare_in;
        end
        // Only the dual-slope mode may run downward
        if (mode != MODE_PFC_PWM) begin
            nxt_st.down = 1'b0;
        end

        // ==========================================================
        // Counter and waveform
        if (tick) begin
            unique case (mode)
                MODE_WATCHDOG: begin
                    if (st_ff.count == period_in) begin
                        nxt_st.count = '0;
                        events[`TC_FLAG_OVF] = 1'b1;
                        // Expiry stays on the pin until a kick, so a late kick is never missed
                        nxt_st.wave = 1'b1;
                    end else begin
                        nxt_st.count = st_ff.count + 16'h0001;
                    end
                end
                MODE_CTC: begin
                    if (st_ff.count == compare_in) begin
                        nxt_st.count = '0;
                        events[`TC_FLAG_CMP] = 1'b1;
                        nxt_st.wave = !st_ff.wave;
                    end else begin
                        nxt_st.count = st_ff.count + 16'h0001;
                    end
                    // Overflow is seen only when the count reaches the top of the range: compare at the top, or set below the count
                    if (st_ff.count == `TC_COUNT_MAX) begin
                        events[`TC_FLAG_OVF] = 1'b1;
                    end
                end
                MODE_FAST_PWM: begin
                    if (st_ff.count >= st_ff.period_buf) begin
                        nxt_st.count = '0;
                        events[`TC_FLAG_OVF] = 1'b1;
                        // Reload only at wrap so a new period never cuts a cycle short
                        nxt_st.period_buf = period_in;
                        nxt_st.compare_buf = compare_in;
                    end else begin
                        nxt_st.count = st_ff.count + 16'h0001;
                    end
                end
                MODE_PFC_PWM: begin
                    if (!st_ff.down) begin
                        if (st_ff.count >= st_ff.period_buf) begin
                            nxt_st.down = 1'b1;
                            nxt_st.count = st_ff.count - 16'h0001;
                        end else begin
                            nxt_st.count = st_ff.count + 16'h0001;
                        end
                    end else if (st_ff.count == 16'h0000) begin
                        // Bottom of the slope: reload keeps both halves symmetric
                        nxt_st.down = 1'b0;
                        events[`TC_FLAG_OVF] = 1'b1;
                        nxt_st.period_buf = period_in;
                        nxt_st.compare_buf = compare_in;
                        nxt_st.count = 16'h0001;
                    end else begin
                        nxt_st.count = st_ff.count - 16'h0001;
                    end
                end
            endcase
            if (is_pwm) begin
                if (nxt_st.count == nxt_st.compare_buf) begin
                    events[`TC_FLAG_CMP] = 1'b1;
                end
                // Registered compare keeps the pin free of decode glitches
                nxt_st.wave = nxt_st.count < nxt_st.compare_buf;
            end else if (mode == MODE_WATCHDOG && st_ff.count == compare_in) begin
                events[`TC_FLAG_CMP] = 1'b1;
            end
        end

        // ==========================================================
        // Watchdog service
        // Software kick restarts the watchdog and drops its expiry output
        if (mode == MODE_WATCHDOG && i_watchdog_kick) begin
            nxt_st.count = '0;
            nxt_st.wave = 1'b0;
        end

        // ==========================================================
        // Input capture
        cap_edge = rose_edge(st_ff.cap_sync, st_ff.cap_prev);
        // In PWM modes the count is not a time base, so capture is refused
        cap_allowed = i_bus_mode && i_capture_enable && !is_pwm;
        if (cap_allowed && cap_edge) begin
            nxt_st.capture = st_ff.count;
            events[`TC_FLAG_CAP] = 1'b1;
        end

        // ==========================================================
        // Pin reset
        // Direct reset pin clears the counting state in either mode
        if (pin_reset) begin
            nxt_st.presc = '0;
            nxt_st.count = '0;
            nxt_st.down = 1'b0;
            nxt_st.wave = 1'b0;
            nxt_st.period_buf = period_in;
            nxt_st.compare_buf = compare_in;
            // A capture that meets the pin reset is dropped together with its flag
            nxt_st.capture = st_ff.capture;
            events = '0;
        end

        // ==========================================================
        // Flags and interrupt outputs; a new event beats a clear in the same cycle
        flags_kept = st_ff.flags & ~i_irq_clear;
        nxt_st.flags = flags_kept | events;
        if (i_bus_mode) begin
            nxt_st.irq = masked_any(nxt_st.flags, i_irq_mask);
            // The standby controller needs an edge, so wake is a one-cycle pulse
            nxt_st.wake = masked_any(events, i_irq_mask);
        end else begin
            nxt_st.irq = nxt_st.flags[`TC_FLAG_OVF];
            nxt_st.wake = events[`TC_FLAG_OVF];
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Status ports
    assign o_count_value = st_ff.count;
    assign o_capture_value_reg = st_ff.capture;
    assign o_waveform_out = st_ff.wave;
    assign o_counter_irq_out = st_ff.irq;
    assign o_wake_irq = st_ff.wake;
    assign o_irq_flags = st_ff.flags;
    assign o_count_down = st_ff.down;

endmodule

`default_nettype wire

/* timer_counter_pwm_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_counter_pwm_properties
    import timer_counter_pwm_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_bus_mode,
    input wire logic [1:0] i_mode,
    input wire logic [2:0] i_prescale_select,
    input wire logic [15:0] i_compare,
    input wire logic i_capture_enable,
    input wire logic [2:0] i_irq_mask,
    input wire logic [2:0] i_irq_clear,
    input wire logic i_watchdog_kick,
    input wire logic i_counter_reset_low,
    input wire logic i_capture_trigger_in,
    input wire logic [15:0] o_count_value,
    input wire logic [15:0] o_capture_value_reg,
    input wire logic o_waveform_out,
    input wire logic o_counter_irq_out,
    input wire logic o_wake_irq,
    input wire logic [2:0] o_irq_flags,
    input wire logic o_count_down
);
    // ==========================================================
    // Port relations
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    a_flags_sticky: assert property (((($past(o_irq_flags) & ~o_irq_flags) & ~$past(i_irq_clear)) == 3'h0))
        else $error("flag dropped without clear");
    a_irq_source: assert property (o_counter_irq_out == ($past(i_bus_mode) ?
        |(o_irq_flags & $past(i_irq_mask)) : o_irq_flags[0]))
        else $error("interrupt output does not follow flags");
    a_wake_masked: assert property (o_wake_irq |-> o_counter_irq_out)
        else $error("wake pulse without interrupt");
    a_down_pfc: assert property (o_count_down |-> $past(i_mode) == MODE_PFC_PWM)
        else $error("down count outside dual slope mode");
    a_stop_hold: assert property (i_bus_mode && i_prescale_select == 3'h0 && !i_watchdog_kick
        && i_counter_reset_low |=> $stable(o_count_value))
        else $error("count moved while stopped");
    a_capture_only: assert property ($changed(o_capture_value_reg) |-> $past(i_bus_mode)
        && !$past(i_mode[1]) && o_irq_flags[2])
        else $error("capture taken where refused");
    a_capture_time: assert property ($rose(i_capture_trigger_in) && i_bus_mode && i_capture_enable
        && !i_mode[1] |-> ##[2:4] o_irq_flags[2])
        else $error("capture flag late");
    a_wave_fall: assert property ($fell(o_waveform_out) && $past(i_bus_mode)
        && $past(i_mode) == MODE_FAST_PWM && $past(i_mode, 2) == MODE_FAST_PWM
        |-> o_count_value == $past(i_compare))
        else $error("waveform fell away from compare");
    a_sa_overflow: assert property (!i_bus_mode && !$past(i_bus_mode) && $rose(o_irq_flags[0])
        |-> o_count_value == 16'h0000)
        else $error("stand-alone overflow at wrong count");
endmodule
bind timer_counter_pwm timer_counter_pwm_properties u_props (.*);
`default_nettype wire

/* timer_counter_pwm_pins.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_counter_pwm_pins (
    output logic o_pin_clk,
    output logic o_pin_cap
);
    // ==========================================================
    // External pins, spaced well above the core period for the synchronisers
    initial begin
        o_pin_clk = 1'b0;
        o_pin_cap = 1'b0;
    end
    task edges(input int n);
        repeat (n) begin
            #23 o_pin_clk = 1'b1;
            #23 o_pin_clk = 1'b0;
        end
    endtask
    task capture;
        #7 o_pin_cap = 1'b1;
        #40 o_pin_cap = 1'b0;
    endtask
endmodule
`default_nettype wire

/* timer_counter_pwm_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %s exp %0h got %0h", n, (e), (g)); end end
module timer_counter_pwm_tb;
    logic clk = 1'b0, rst = 1'b1, bus = 1'b0, cen = 1'b0, kick = 1'b0, rstn = 1'b1, w;
    logic [1:0] mode = 2'h0, csel = 2'h0;
    logic [2:0] psel = 3'h1, mask = 3'h0, clr = 3'h0, flags;
    logic [15:0] per = 16'h0000, cmp = 16'h0000, cnt, cap, c0;
    logic wave, irq, wake, down, pclk, pcap;
    int n_mismatch = 0, n_checks = 0, k, cycles = 0;
    timer_counter_pwm dut (.i_core_clk(clk), .i_reset(rst), .i_bus_mode(bus), .i_mode(mode),
        .i_clock_select(csel), .i_prescale_select(psel), .i_period(per), .i_compare(cmp),
        .i_capture_enable(cen), .i_irq_mask(mask), .i_irq_clear(clr), .i_watchdog_kick(kick),
        .i_counter_clock_in(pclk), .i_counter_reset_low(rstn), .i_capture_trigger_in(pcap),
        .o_count_value(cnt), .o_capture_value_reg(cap), .o_waveform_out(wave),
        .o_counter_irq_out(irq), .o_wake_irq(wake), .o_irq_flags(flags), .o_count_down(down));
    timer_counter_pwm_pins pins (.o_pin_clk(pclk), .o_pin_cap(pcap));
    // ==========================================================
    // Clock, watchdog on the run, helpers
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task cfg(input logic [1:0] m, input logic [2:0] p, input logic [15:0] pr, input logic [15:0] cm);
        mode = m;
        psel = p;
        per = pr;
        cmp = cm;
        rst = 1'b1;
        step(2);
        rst = 1'b0;
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // Sequence
    initial begin
        step(16);
        rst = 1'b0;
        `CHK("count", 16'h0, cnt)
        for (k = 0; k < 700 && flags[0] !== 1'b1; k++) step(1);
        `CHK("sa_wrap", 16'h0, cnt)
        `CHK("sa_irq", 1'b1, irq)
        rstn = 1'b0;
        step(5);
        `CHK("pin_rst", 16'h0, cnt)
        `CHK("flag_kept", 1'b1, flags[0])
        rstn = 1'b1;
        clr = 3'h1;
        step(1);
        clr = 3'h0;
        `CHK("ovf_clr", 1'b0, flags[0])
        `CHK("irq_clr", 1'b0, irq)
        // Fast PWM walk with period 3 and compare 2
        bus = 1'b1;
        mask = 3'h7;
        cfg(2'h2, 3'h1, 16'h3, 16'h2);
        for (k = 0; k < 20 && cnt !== 16'h3; k++) step(1);
        w = 1'b0;
        repeat (8) begin
            c0 = cnt;
            step(1);
            w |= wake;
            `CHK("walk", (c0 == 16'h3) ? 16'h0 : c0 + 16'h1, cnt)
            `CHK("wave", cnt < 16'h2, wave)
        end
        `CHK("flags", 3'h3, flags)
        `CHK("wake", 1'b1, w)
        mask = 3'h4;
        step(1);
        `CHK("mask_ovf", 1'b0, irq)
        cfg(2'h2, 3'h2, 16'hff, 16'h80);
        step(3);
        c0 = cnt;
        step(80);
        `CHK("div8", c0 + 16'ha, cnt)
        psel = 3'h0;
        step(1);
        c0 = cnt;
        step(20);
        `CHK("stop", c0, cnt)
        psel = 3'h1;
        csel = 2'h1;
        step(1);
        c0 = cnt;
        pins.edges(6);
        step(4);
        `CHK("pin_clk", c0 + 16'h6, cnt)
        csel = 2'h2;
        step(1);
        c0 = cnt;
        pins.edges(2);
        step(4);
        `CHK("pin_fall", c0 + 16'h2, cnt)
        // Count is frozen here so the time stamp is exact
        mode = 2'h1;
        cmp = 16'hffff;
        cen = 1'b1;
        mask = 3'h4;
        step(1);
        `CHK("masked", 1'b0, irq)
        pins.capture();
        for (k = 0; k < 10 && flags[2] !== 1'b1; k++) step(1);
        `CHK("stamp", 16'h12, cap)
        `CHK("cap_irq", 1'b1, irq)
        clr = 3'h4;
        mode = 2'h2;
        step(1);
        clr = 3'h0;
        pins.capture();
        step(8);
        `CHK("cap_pwm", 1'b0, flags[2])
        csel = 2'h0;
        cfg(2'h3, 3'h1, 16'h4, 16'h2);
        c0 = 16'h0;
        w = 1'b0;
        repeat (24) begin
            step(1);
            if (cnt > c0) c0 = cnt;
            w |= down;
        end
        `CHK("pfc_top", 16'h4, c0)
        `CHK("pfc_down", 1'b1, w)
        cfg(2'h0, 3'h1, 16'h5, 16'h3);
        for (k = 0; k < 20 && flags[0] !== 1'b1; k++) step(1);
        `CHK("wd_wave", 1'b1, wave)
        `CHK("wd_count", 16'h0, cnt)
        `CHK("wd_cmp", 1'b1, flags[1])
        kick = 1'b1;
        step(1);
        kick = 1'b0;
        `CHK("wd_kick", 1'b0, wave)
        cfg(2'h1, 3'h1, 16'h0, 16'h3);
        for (k = 0; k < 20 && flags[1] !== 1'b1; k++) step(1);
        `CHK("ctc_wrap", 16'h0, cnt)
        `CHK("ctc_wave", 1'b1, wave)
        step(4);
        `CHK("ctc_toggle", 1'b0, wave)
        complete_run();
    end
endmodule
`default_nettype wire
